// >>> common/timer8_pkg.sv
/*
  Package for the 8-bit waveform timer: register offsets, field positions,
  reset values, mode encodings and the bus carrier types.
  Assumes a 32-bit APB host and a single pclk domain.
*/
package timer8_pkg;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_COMPARE = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_PRESCALE = 8'h10;

  localparam int CTRL_WAVE_LSB = 0;
  localparam int CTRL_COM_LSB = 2;
  localparam int CTRL_DIR_BIT = 4;
  localparam int CTRL_FORCE_BIT = 8;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_BIT = 1;

  localparam logic [1:0] WAVE_RESET = 2'h0;
  localparam logic [1:0] COM_RESET = 2'h0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [15:0] PRESCALE_RESET = 16'h0000;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  typedef enum logic [1:0] {
    WAVE_NORMAL = 2'h0,
    WAVE_PHASE_PWM = 2'h1,
    WAVE_CLEAR_ON_MATCH = 2'h2,
    WAVE_FAST_PWM = 2'h3
  } waveform_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

endpackage

// >>> rtl/timer8_waveform_modes.sv
/*
  Holds the 8-bit timer counter, compare unit, waveform generator and the
  shared pin override, with an APB register slave.
  Assumes a port block that supplies its own output value only (the direction
  bit is held here) and resolves the pin from the enable driven here.
*/
// What this block does
// - Nonzero output mode overrides port output value.
// - Direction bit alone enables the pin driver.
// - Pin override ignores the waveform mode.
// - Output mode zero leaves output state alone.
// - New output mode acts next match; force.
// - Only waveform mode sets the counting sequence.
// - Normal mode counts up, wraps FF to 00.
// - Normal overflow flag set as count hits zero.
// - Count may be written at any time.
// - Clear-on-match counts to compare, then clears.
// - Compare unbuffered there; missed match wraps around.
// - Clear-on-match sets match flag each period.
// - Clear-on-match mode one toggles each match.
// - Clear-on-match overflow set passing max to zero.
// - Fast PWM counts zero to max, clears after.
// - Fast PWM polarity from modes two, three.
// - Fast PWM overflow flag set at max.
// - Fast PWM extremes: spike or constant level.
// - Fast PWM mode one toggles, fifty percent.
// - Fast PWM period is 256 timer ticks.
// - Phase PWM counts up then down, symmetric.
// - Match flag set next tick, write-one clears.
// - PWM compare writes buffered until top/bottom.
`timescale 1ns/1ps
module timer8_waveform_modes
(
  input wire logic pclk,
  input wire logic presetn,
  input wire timer8_pkg::apb_req_t apb_req,
  output timer8_pkg::apb_rsp_t apb_rsp,
  input wire logic port_out_value,
  output logic pin_out,
  output logic pin_oe,
  output logic compare_output_state,
  output logic overflow_flag,
  output logic compare_match_flag
);

  logic [1:0] wave_r;
  logic [1:0] com_r;
  logic dir_r;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [7:0] compare_r;
  logic [7:0] compare_buf_r;
  logic [15:0] prescale_r;
  logic [15:0] div_r;
  logic tick;
  logic down_r;
  logic block_r;
  logic state_r;
  logic state_nxt;
  logic ovf_r;
  logic cmp_r;
  logic match;
  logic match_seen;
  logic force_hit;
  logic is_pwm;
  logic wr;
  logic rd_en;
  logic [31:0] rdata_r;
  logic err_r;

  // Decodes which register an address selects; unmapped gives 3'h7.
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    case (a)
      timer8_pkg::ADDR_CTRL: reg_sel = 3'h0;
      timer8_pkg::ADDR_COUNT: reg_sel = 3'h1;
      timer8_pkg::ADDR_COMPARE: reg_sel = 3'h2;
      timer8_pkg::ADDR_FLAGS: reg_sel = 3'h3;
      timer8_pkg::ADDR_PRESCALE: reg_sel = 3'h4;
      default: reg_sel = 3'h7;
    endcase
  endfunction

  // Zero-wait slave: every access completes in its first access cycle.
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = err_r && apb_req.penable;
  assign apb_rsp.prdata = rdata_r;

  assign is_pwm = (wave_r == timer8_pkg::WAVE_PHASE_PWM) || (wave_r == timer8_pkg::WAVE_FAST_PWM);
  assign force_hit = wr && (reg_sel(apb_req.paddr) == 3'h0) && !is_pwm
    && apb_req.pwdata[timer8_pkg::CTRL_FORCE_BIT];

  // Timer tick: one pclk pulse every prescale_r+1 cycles, standing in for the timer clock.
  assign tick = (div_r == prescale_r);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_r <= 16'h0000;
    else if (tick)
      div_r <= 16'h0000;
    else
      div_r <= div_r + 16'h0001;
  end

  // Comparator output; a count write masks the next tick's match.
  assign match = (count_r == compare_r) && !block_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      block_r <= 1'b0;
    else if (wr && (reg_sel(apb_req.paddr) == 3'h1))
      block_r <= 1'b1;
    else if (tick)
      block_r <= 1'b0;
  end

  // Next count depends on waveform mode only; output mode never enters here.
  always_comb
  begin
    count_nxt = count_r + 8'h01;
    case (wave_r)
      timer8_pkg::WAVE_NORMAL: count_nxt = count_r + 8'h01;
      timer8_pkg::WAVE_CLEAR_ON_MATCH:
        count_nxt = match ? timer8_pkg::COUNT_BOTTOM : count_r + 8'h01;
      timer8_pkg::WAVE_FAST_PWM:
        count_nxt = (count_r == timer8_pkg::COUNT_MAX) ? timer8_pkg::COUNT_BOTTOM
          : count_r + 8'h01;
      timer8_pkg::WAVE_PHASE_PWM:
        count_nxt = ((down_r && count_r != timer8_pkg::COUNT_BOTTOM)
          || count_r == timer8_pkg::COUNT_MAX) ? count_r - 8'h01 : count_r + 8'h01;
      default: count_nxt = count_r + 8'h01;
    endcase
  end

  // A software write of the count wins over the tick's own update.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_r <= timer8_pkg::COUNT_RESET;
    else if (wr && (reg_sel(apb_req.paddr) == 3'h1))
      count_r <= apb_req.pwdata[7:0];
    else if (tick)
      count_r <= count_nxt;
  end

  // Direction turns at the ends of the dual slope.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      down_r <= 1'b0;
    else if (wave_r != timer8_pkg::WAVE_PHASE_PWM)
      down_r <= 1'b0;
    else if (tick && count_r == timer8_pkg::COUNT_MAX)
      down_r <= 1'b1;
    else if (tick && count_r == timer8_pkg::COUNT_BOTTOM)
      down_r <= 1'b0;
  end

  // Compare value: direct in non-PWM modes, buffered in PWM modes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      compare_buf_r <= timer8_pkg::COMPARE_RESET;
    else if (wr && (reg_sel(apb_req.paddr) == 3'h2))
      compare_buf_r <= apb_req.pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      compare_r <= timer8_pkg::COMPARE_RESET;
    else if (!is_pwm)
      compare_r <= (wr && (reg_sel(apb_req.paddr) == 3'h2)) ? apb_req.pwdata[7:0]
        : compare_buf_r;
    else if (tick && wave_r == timer8_pkg::WAVE_FAST_PWM && count_r == timer8_pkg::COUNT_MAX)
      compare_r <= compare_buf_r;
    else if (tick && wave_r == timer8_pkg::WAVE_PHASE_PWM && count_r == timer8_pkg::COUNT_MAX)
      compare_r <= compare_buf_r;
  end

  // Waveform generator; output mode is read live so a change acts at the next match.
  always_comb
  begin
    state_nxt = state_r;
    if (force_hit)
    begin
      case (com_r)
        2'h1: state_nxt = !state_r;
        2'h2: state_nxt = 1'b0;
        2'h3: state_nxt = 1'b1;
        default: state_nxt = state_r;
      endcase
    end
    else if (tick)
    begin
      case (wave_r)
        timer8_pkg::WAVE_NORMAL, timer8_pkg::WAVE_CLEAR_ON_MATCH:
          if (match)
          begin
            case (com_r)
              2'h1: state_nxt = !state_r;
              2'h2: state_nxt = 1'b0;
              2'h3: state_nxt = 1'b1;
              default: state_nxt = state_r;
            endcase
          end
        timer8_pkg::WAVE_FAST_PWM:
          case (com_r)
            2'h1: state_nxt = match ? !state_r : state_r;
            // Match at max comes after bottom's set, so a max compare holds steady.
            2'h2: state_nxt = match ? 1'b0 : (count_r == timer8_pkg::COUNT_MAX) ? 1'b1
              : state_r;
            2'h3: state_nxt = match ? 1'b1 : (count_r == timer8_pkg::COUNT_MAX) ? 1'b0
              : state_r;
            default: state_nxt = state_r;
          endcase
        timer8_pkg::WAVE_PHASE_PWM:
          if (match && com_r[1])
            state_nxt = down_r ^ com_r[0];
        default: state_nxt = state_r;
      endcase
    end
  end

  // The state holds across mode changes so it can be primed before the pin is driven.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= 1'b0;
    else
      state_r <= state_nxt;
  end

  // Overflow event per mode; the set beats a same-cycle write-one clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovf_r <= 1'b0;
    else if (tick && wave_r != timer8_pkg::WAVE_PHASE_PWM && count_r == timer8_pkg::COUNT_MAX)
      ovf_r <= 1'b1;
    else if (tick && wave_r == timer8_pkg::WAVE_PHASE_PWM && down_r
      && count_r == 8'h01)
      ovf_r <= 1'b1;
    else if (wr && (reg_sel(apb_req.paddr) == 3'h3) && apb_req.pwdata[timer8_pkg::FLAG_OVF_BIT])
      ovf_r <= 1'b0;
  end

  // Match flag rises on the tick after the count equals the compare value.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      match_seen <= 1'b0;
    else if (tick)
      match_seen <= match;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmp_r <= 1'b0;
    else if (tick && match_seen)
      cmp_r <= 1'b1;
    else if (wr && (reg_sel(apb_req.paddr) == 3'h3) && apb_req.pwdata[timer8_pkg::FLAG_CMP_BIT])
      cmp_r <= 1'b0;
  end

  // Control and prescale registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wave_r <= timer8_pkg::WAVE_RESET;
      com_r <= timer8_pkg::COM_RESET;
      dir_r <= 1'b0;
    end
    else if (wr && (reg_sel(apb_req.paddr) == 3'h0))
    begin
      wave_r <= apb_req.pwdata[timer8_pkg::CTRL_WAVE_LSB +: 2];
      com_r <= apb_req.pwdata[timer8_pkg::CTRL_COM_LSB +: 2];
      dir_r <= apb_req.pwdata[timer8_pkg::CTRL_DIR_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prescale_r <= timer8_pkg::PRESCALE_RESET;
    else if (wr && (reg_sel(apb_req.paddr) == 3'h4))
      prescale_r <= apb_req.pwdata[15:0];
  end

  // Read data captured in the setup cycle so it is stable through the access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_r <= 32'h00000000;
      err_r <= 1'b0;
    end
    else if (apb_req.psel && !apb_req.penable)
    begin
      err_r <= (reg_sel(apb_req.paddr) == 3'h7);
      rdata_r <= 32'h00000000;
      if (rd_en)
      begin
        case (reg_sel(apb_req.paddr))
          3'h0: rdata_r <= {27'h0, dir_r, com_r, wave_r};
          3'h1: rdata_r <= {24'h0, count_r};
          3'h2: rdata_r <= {24'h0, compare_buf_r};
          3'h3: rdata_r <= {30'h0, cmp_r, ovf_r};
          3'h4: rdata_r <= {16'h0, prescale_r};
          default: rdata_r <= 32'h00000000;
        endcase
      end
    end
  end

  // Pin mux: only the output-mode field picks the source, the direction bit the driver.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end
    else
    begin
      pin_out <= (com_r != 2'h0) ? state_r : port_out_value;
      pin_oe <= dir_r;
    end
  end

  assign compare_output_state = state_r;
  assign overflow_flag = ovf_r;
  assign compare_match_flag = cmp_r;

endmodule

// >>> dv/timer8_assertions.sv
/* Checker for the waveform timer ports.
   Sees only the top module ports; one pclk domain. */
`timescale 1ns/1ps
module timer8_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire timer8_pkg::apb_req_t apb_req,
  input wire timer8_pkg::apb_rsp_t apb_rsp,
  input wire logic port_out_value,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic compare_output_state,
  input wire logic overflow_flag,
  input wire logic compare_match_flag
);
  logic wr;
  logic fw;
  logic [1:0] com_r;
  logic [1:0] wave_r;
  logic dir_r;
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
  assign fw = wr && apb_req.paddr == timer8_pkg::ADDR_FLAGS;
  // Shadow of the control word, updated on the same edge as the block's own.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      com_r <= 2'h0;
      wave_r <= 2'h0;
      dir_r <= 1'b0;
    end
    else if (wr && apb_req.paddr == timer8_pkg::ADDR_CTRL)
    begin
      com_r <= apb_req.pwdata[3:2];
      wave_r <= apb_req.pwdata[1:0];
      dir_r <= apb_req.pwdata[4];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_pin_port_value: assert property (
    com_r == 2'h0 |=> pin_out == $past(port_out_value)) else $error("pin not port value");
  chk_pin_state_value: assert property (
    com_r != 2'h0 |=> pin_out == $past(compare_output_state)) else $error("pin not state");
  chk_dir_enable: assert property (
    1'b1 |=> pin_oe == $past(dir_r)) else $error("pin enable wrong");
  chk_mode_zero_hold: assert property (
    com_r == 2'h0 |=> $stable(compare_output_state)) else $error("state moved");
  chk_ovf_sticky: assert property (
    $fell(overflow_flag) |-> $past(fw && apb_req.pwdata[0])) else $error("ovf cleared");
  chk_cmp_sticky: assert property (
    $fell(compare_match_flag) |-> $past(fw && apb_req.pwdata[1])) else $error("cmf cleared");
  chk_fast_set_bottom: assert property (
    $rose(compare_output_state) && wave_r == 2'h3 && com_r == 2'h2
    && $past(wave_r) == 2'h3 && $past(com_r) == 2'h2 |-> overflow_flag)
    else $error("set not at bottom");
  chk_unmapped_err: assert property (
    apb_req.psel && apb_req.penable && apb_req.paddr > timer8_pkg::ADDR_PRESCALE
    |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("unmapped not refused");
  cover property ($rose(overflow_flag));
  cover property ($rose(compare_match_flag));
  cover property (pin_oe && com_r != 2'h0);
endmodule
bind timer8_waveform_modes timer8_checker chk_u (.pclk, .presetn, .apb_req, .apb_rsp,
  .port_out_value, .pin_out, .pin_oe, .compare_output_state, .overflow_flag,
  .compare_match_flag);

// >>> dv/timer8_port_model.sv
/* Port pin model: general output value and pad level.
   Assumes the timer drives pin_out and pin_oe in the pclk domain. */
`timescale 1ns/1ps
module timer8_port_model
(
  input wire logic pclk,
  input wire logic drive_val,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic port_out_value,
  output logic pin_level
);
  // The pad has a pull-up, so an undriven pin reads high.
  assign pin_level = pin_oe ? pin_out : 1'b1;
  always @(posedge pclk)
  begin
    port_out_value <= drive_val;
  end
endmodule

// >>> dv/tb_timer8_waveform_modes.sv
/* Self-checking bench for the waveform timer.
   Assumes prescale 0, so the timer ticks every pclk. */
`timescale 1ns/1ps
module tb_timer8_waveform_modes;
  logic pclk;
  logic presetn;
  timer8_pkg::apb_req_t req;
  timer8_pkg::apb_rsp_t rsp;
  logic drive_val, port_out_value, pin_out, pin_oe, cos, ovf, cmf, pin_level, err;
  int error_cnt;
  int check_count;
  int n;
  int h;
  logic [31:0] rd;
  timer8_waveform_modes dut_u (.pclk, .presetn, .apb_req(req), .apb_rsp(rsp), .port_out_value,
    .pin_out, .pin_oe, .compare_output_state(cos), .overflow_flag(ovf),
    .compare_match_flag(cmf));
  timer8_port_model port_u (.pclk, .drive_val, .pin_out, .pin_oe, .port_out_value, .pin_level);
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk);
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  // Counts edges until the output state takes the wanted level.
  task automatic wait_cos(input logic v, output int k);
    k = 0;
    do
    begin
      @(posedge pclk);
      #1;
      k++;
    end
    while (cos !== v && k < 600);
  endtask
  task automatic t_regs();
    apb(0, timer8_pkg::ADDR_CTRL, 0);
    check(rd, 32'h0);
    apb(1, timer8_pkg::ADDR_CTRL, 32'h113);
    apb(0, timer8_pkg::ADDR_CTRL, 0);
    check(rd, 32'h13);
    apb(1, 8'h14, 32'hFF);
    apb(0, 8'h14, 0);
    check(err, 1'b1);
    check(rd, 32'h0);
    apb(1, timer8_pkg::ADDR_COMPARE, 32'h5A);
    apb(0, timer8_pkg::ADDR_COMPARE, 0);
    check(rd, 32'h5A);
    $display("done regs");
  endtask
  task automatic t_normal();
    apb(1, timer8_pkg::ADDR_CTRL, 32'h0);
    apb(1, timer8_pkg::ADDR_COUNT, 32'h10);
    apb(1, timer8_pkg::ADDR_FLAGS, 32'h3);
    apb(1, timer8_pkg::ADDR_COUNT, 32'hFD);
    n = 0;
    do
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    while (ovf !== 1'b1 && n < 300);
    check(n, 3);
    repeat (40) @(posedge pclk);
    check(ovf, 1'b1);
    apb(1, timer8_pkg::ADDR_FLAGS, 32'h1);
    #1;
    check(ovf, 1'b0);
    $display("done normal");
  endtask
  task automatic t_pins();
    apb(1, timer8_pkg::ADDR_CTRL, 32'h10);
    drive_val <= 1'b1;
    repeat (3) @(posedge pclk);
    check(pin_level, 1'b1);
    drive_val <= 1'b0;
    repeat (3) @(posedge pclk);
    check(pin_level, 1'b0);
    apb(1, timer8_pkg::ADDR_COMPARE, 32'h80);
    apb(1, timer8_pkg::ADDR_CTRL, 32'h04);
    h = cos;
    apb(1, timer8_pkg::ADDR_CTRL, 32'h104);
    repeat (2) @(posedge pclk);
    check(cos, !h);
    check(pin_level, 1'b1);
    apb(1, timer8_pkg::ADDR_CTRL, 32'h0);
    apb(1, timer8_pkg::ADDR_CTRL, 32'h100);
    repeat (2) @(posedge pclk);
    check(cos, !h);
    $display("done pins");
  endtask
  task automatic t_ctc();
    apb(1, timer8_pkg::ADDR_COMPARE, 32'h4);
    apb(1, timer8_pkg::ADDR_CTRL, 32'h16);
    apb(1, timer8_pkg::ADDR_FLAGS, 32'h3);
    wait_cos(!cos, n);
    wait_cos(!cos, n);
    check(n, 5);
    check(cmf, 1'b1);
    @(posedge pclk);
    #1;
    check(pin_level, cos);
    apb(1, timer8_pkg::ADDR_COUNT, 32'h10);
    apb(1, timer8_pkg::ADDR_FLAGS, 32'h3);
    wait_cos(!cos, n);
    check(n > 240 && n < 250, 1'b1);
    check(ovf, 1'b1);
    $display("done ctc");
  endtask
  task automatic t_pwm();
    logic [7:0] cfg [4] = '{8'h0B, 8'h0F, 8'h09, 8'h07};
    int per [4] = '{256, 256, 510, 512};
    int hs;
    hs = 0;
    apb(1, timer8_pkg::ADDR_CTRL, 32'h0);
    apb(1, timer8_pkg::ADDR_COMPARE, 32'h40);
    apb(1, timer8_pkg::ADDR_FLAGS, 32'h3);
    for (int i = 0; i < 4; i++)
    begin
      apb(1, timer8_pkg::ADDR_CTRL, {24'h0, cfg[i]});
      wait_cos(0, n);
      wait_cos(1, n);
      wait_cos(0, h);
      wait_cos(1, n);
      check(h + n, per[i]);
      if (i < 2)
        hs += h;
      if (i == 0)
        check(ovf, 1'b1);
      if (i == 2)
        check(h, 128);
      if (i == 3)
        check(h, 256);
    end
    check(hs, 256);
    $display("done pwm");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    test_done();
  end
  initial
  begin
    presetn = 1'b0;
    req = '0;
    drive_val = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_normal();
    t_pins();
    t_ctc();
    t_pwm();
    test_done();
  end
endmodule
